// File: core/asrp_pkg.sv
package asrp_pkg;
  // byte addresses on the bus
  localparam logic [31:0] CTRL_ADDR   = 32'hb000_9004;
  localparam logic [31:0] STAT_ADDR   = 32'hb000_904c;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  // only documented control fields take writes
  localparam logic [31:0] CTRL_WMASK  = 32'h0001_f1fb;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
  localparam int          DATA_W      = 32;
  localparam int          LANE_W      = 8;
  localparam int          LANES       = 4;
  // control field positions
  localparam int GLB_RST_BIT   = 16;
  localparam int REC_SEL_HI    = 15;
  localparam int REC_SEL_LO    = 14;
  localparam int PLAY_SEL_HI   = 13;
  localparam int PLAY_SEL_LO   = 12;
  localparam int CL_REC_BIT    = 8;
  localparam int CL_PLAY_BIT   = 7;
  localparam int I2S_REC_BIT   = 6;
  localparam int I2S_PLAY_BIT  = 5;
  localparam int CNT_EN_BIT    = 4;
  localparam int ZERO_EN_BIT   = 3;
  localparam int CL_RST_BIT    = 1;
  localparam int I2S_RST_BIT   = 0;
  // channel select codes
  localparam logic [1:0] REC_DUAL    = 2'h3;
  localparam logic [1:0] REC_LEFT    = 2'h1;
  localparam logic [1:0] REC_RIGHT   = 2'h2;
  localparam logic [1:0] PLAY_STEREO = 2'h3;
  localparam logic [1:0] PLAY_MONO   = 2'h2;
  // status field positions
  localparam int ST_I2S_RST    = 0;
  localparam int ST_CL_RST     = 1;
  localparam int ST_GLB_RST    = 2;
  localparam int ST_REC_LEFT   = 3;
  localparam int ST_REC_RIGHT  = 4;
  localparam int ST_PLAY_ST    = 5;
  localparam int ST_PLAY_MONO  = 6;
  localparam int ST_REC_BAD    = 7;
  localparam int ST_PLAY_BAD   = 8;
endpackage

// File: core/asrp_rst_gen.sv
`timescale 1ns/1ps
`default_nettype none
module asrp_rst_gen
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic glb_req_i,
  input  wire logic i2s_req_i,
  input  wire logic cl_req_i,
  output logic      glb_rst_o,
  output logic      i2s_rst_o,
  output logic      cl_rst_o
);
  // sub-blocks stay in reset while the system reset is up
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      glb_rst_o <= 1'b1;
      i2s_rst_o <= 1'b1;
      cl_rst_o  <= 1'b1;
    end
    else if (ce_i)
    begin
      glb_rst_o <= glb_req_i;
      i2s_rst_o <= glb_req_i | i2s_req_i;
      cl_rst_o  <= glb_req_i | cl_req_i;
    end
  end
endmodule
`default_nettype wire

// File: core/asrp_chan_dec.sv
`timescale 1ns/1ps
`default_nettype none
module asrp_chan_dec
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [1:0] rec_sel_i,
  input  wire logic [1:0] play_sel_i,
  input  wire logic       adc_src_i,
  output logic            rec_left_o,
  output logic            rec_right_o,
  output logic            rec_bad_o,
  output logic            play_stereo_o,
  output logic            play_mono_o,
  output logic            play_bad_o
);
  // reserved codes open no channel and raise a flag instead, except record code 00 with the converter source, which opens left
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rec_left_o    <= 1'b0;
      rec_right_o   <= 1'b0;
      rec_bad_o     <= 1'b0;
      play_stereo_o <= 1'b0;
      play_mono_o   <= 1'b0;
      play_bad_o    <= 1'b0;
    end
    else if (ce_i)
    begin
      // the converter source is mono: left only, whatever the code
      rec_left_o    <= adc_src_i ? 1'b1 :
                       (rec_sel_i == asrp_pkg::REC_DUAL) |
                       (rec_sel_i == asrp_pkg::REC_LEFT);
      rec_right_o   <= ~adc_src_i &
                       ((rec_sel_i == asrp_pkg::REC_DUAL) |
                        (rec_sel_i == asrp_pkg::REC_RIGHT));
      rec_bad_o     <= ~adc_src_i & (rec_sel_i == 2'h0);
      play_stereo_o <= (play_sel_i == asrp_pkg::PLAY_STEREO);
      play_mono_o   <= (play_sel_i == asrp_pkg::PLAY_MONO);
      play_bad_o    <= ~play_sel_i[1];
    end
  end
endmodule
`default_nettype wire

// File: core/asrp_ctrl.sv
// Operation
// - Bit 16 set holds the whole audio controller in reset, cleared lets it run.
// - Record select 11 records both channels, 01 left only, 10 right only, 00 is reserved.
// - With the converter as record source only the left channel is recorded.
// - Playback select 11 is stereo, 10 is mono, 00 and 01 are reserved.
// - Bit 8 enables the codec-link record path.
// - Bit 7 enables the codec-link playback path.
// - Bit 6 enables the I2S record path.
// - Bit 5 enables the I2S playback path.
// - Bit 4 enables the DMA countdown function, else it stays idle.
// - Bit 3 enables zero and sign detection on DMA sample data.
// - Bit 1 holds the codec-link sub-block in reset while set.
// - Bit 0 holds the I2S sub-block in reset while set.
// - All control fields are read/write and the register resets to zero.
`timescale 1ns/1ps
`default_nettype none
module asrp_ctrl
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // classic wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // record source from the controller: converter selected
  input  wire logic        adc_src_i,
  // resets toward the controller and its sub-blocks
  output logic             audio_ctrl_global_rst_o,
  output logic             i2s_subblock_rst_o,
  output logic             codec_link_subblock_rst_o,
  // path enables
  output logic             codec_link_record_en_o,
  output logic             codec_link_play_en_o,
  output logic             i2s_record_en_o,
  output logic             i2s_play_en_o,
  output logic             dma_count_en_o,
  output logic             dma_zero_det_en_o,
  // channel layout
  output logic             rec_left_en_o,
  output logic             rec_right_en_o,
  output logic             play_stereo_o,
  output logic             play_mono_o
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode, used by both the write and the read side
  // full 32-bit compare: the block maps its control and status
  // words only, since an alias would let a stray pointer hit the resets

  function automatic logic addr_hit
  (
    input logic [31:0] adr,
    input logic [31:0] target
  );
    addr_hit = (adr == target);
  endfunction

  logic        req;
  logic        wr_ctrl;
  logic        rd_ctrl;
  logic        rd_stat;
  logic [31:0] ctrl;
  logic [31:0] stat;
  logic [31:0] lane_mask;
  logic [31:0] next_ctrl;
  logic [31:0] next_dat;

  // a new request is one not yet acknowledged
  assign req     = cyc_i & stb_i & ~ack_o;
  assign wr_ctrl = req & we_i & addr_hit(adr_i, asrp_pkg::CTRL_ADDR);
  assign rd_ctrl = addr_hit(adr_i, asrp_pkg::CTRL_ADDR);
  assign rd_stat = addr_hit(adr_i, asrp_pkg::STAT_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // byte lanes: sel_i widens into a bit mask

  genvar g;
  generate
    for (g = 0; g < asrp_pkg::LANES; g++)
    begin : g_lane
      assign lane_mask[g*asrp_pkg::LANE_W +: asrp_pkg::LANE_W] =
        {asrp_pkg::LANE_W{sel_i[g]}};
    end
  endgenerate

  // a lane left low keeps its byte as it was
  // reserved positions never take a write, so they stay zero
  assign next_ctrl = (ctrl & ~(lane_mask & asrp_pkg::CTRL_WMASK)) |
                     (dat_i & lane_mask & asrp_pkg::CTRL_WMASK);

  ////////////////////////////////////////////////////////////////////////////
  // control register

  // control word layout
  //   [31:17] reserved, read as zero
  //   [16]    global reset of the whole controller
  //   [15:14] record channel code: 11 both, 01 left, 10 right, 00 none
  //   [13:12] playback code: 11 stereo, 10 mono, 0x none
  //   [11:9]  reserved, read as zero
  //   [8]     codec-link record path
  //   [7]     codec-link playback path
  //   [6]     i2s record path
  //   [5]     i2s playback path
  //   [4]     dma countdown
  //   [3]     dma zero and sign detection
  //   [2]     reserved, read as zero
  //   [1]     codec-link sub-block reset
  //   [0]     i2s sub-block reset
  // the word keeps what software wrote; the global reset bit gates the path and
  // dma enables but does not clear the word, so software can drop the bit
  // and resume with the settings it already made
  // written on the edge that raises ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= asrp_pkg::CTRL_RESET;
    end
    else if (ce_i && wr_ctrl)
    begin
      ctrl <= next_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer

  // timing of one access, edges counted from the one that takes it:
  //   edge 0: request seen, write lands, read word captured, ack rises
  //   edge 1: ack falls; the master must have dropped stb by now, or
  //           the request is taken again at edge 2
  //   edge 1: derived outputs show the new control word
  // a low clock enable stretches every step by the cycles it is low
  // every request gets ack one cycle later, mapped or not, so a stray
  // access never hangs the bus; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_o <= req;
    end
  end

  // read mux; only the control and status words are mapped
  always_comb
  begin
    next_dat = asrp_pkg::ZERO_WORD;
    if (rd_ctrl)
    begin
      next_dat = ctrl & asrp_pkg::CTRL_WMASK;
    end
    else if (rd_stat)
    begin
      next_dat = stat;
    end
  end

  // data register holds its value until the next read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= asrp_pkg::ZERO_WORD;
    end
    else if (ce_i && req && !we_i)
    begin
      dat_o <= next_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset outputs
  // the three reset outputs start high and stay high for one enabled edge
  // after the system reset lifts, so the sub-blocks see a clean reset
  // even when software never touches the word; a zero word then lets
  // them run

  asrp_rst_gen u_rst
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .glb_req_i (ctrl[asrp_pkg::GLB_RST_BIT]),
    .i2s_req_i (ctrl[asrp_pkg::I2S_RST_BIT]),
    .cl_req_i  (ctrl[asrp_pkg::CL_RST_BIT]),
    .glb_rst_o (audio_ctrl_global_rst_o),
    .i2s_rst_o (i2s_subblock_rst_o),
    .cl_rst_o  (codec_link_subblock_rst_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // channel layout

  asrp_chan_dec u_chan
  (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ce_i          (ce_i),
    .rec_sel_i     (ctrl[asrp_pkg::REC_SEL_HI:asrp_pkg::REC_SEL_LO]),
    .play_sel_i    (ctrl[asrp_pkg::PLAY_SEL_HI:asrp_pkg::PLAY_SEL_LO]),
    .adc_src_i     (adc_src_i),
    .rec_left_o    (rec_left_en_o),
    .rec_right_o   (rec_right_en_o),
    .rec_bad_o     (stat[asrp_pkg::ST_REC_BAD]),
    .play_stereo_o (play_stereo_o),
    .play_mono_o   (play_mono_o),
    .play_bad_o    (stat[asrp_pkg::ST_PLAY_BAD])
  );

  ////////////////////////////////////////////////////////////////////////////
  // path enables
  // each enable is its own register so that a change in one path never
  // glitches another; all follow the control word one enabled edge late,
  // which keeps every output straight from a flip-flop

  logic glb_hold;
  logic i2s_hold;
  logic cl_hold;

  // a path in a held sub-block is kept off, so it cannot start a
  // transfer the instant its reset lifts before software is ready
  assign glb_hold = ctrl[asrp_pkg::GLB_RST_BIT];
  assign i2s_hold = glb_hold | ctrl[asrp_pkg::I2S_RST_BIT];
  assign cl_hold  = glb_hold | ctrl[asrp_pkg::CL_RST_BIT];

  // codec-link record path
  // off while the codec-link sub-block or the whole controller is held
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      codec_link_record_en_o <= 1'b0;
    end
    else if (ce_i)
    begin
      codec_link_record_en_o <= ctrl[asrp_pkg::CL_REC_BIT] & ~cl_hold;
    end
  end

  // codec-link playback path
  // off while the codec-link sub-block or the whole controller is held
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      codec_link_play_en_o <= 1'b0;
    end
    else if (ce_i)
    begin
      codec_link_play_en_o <= ctrl[asrp_pkg::CL_PLAY_BIT] & ~cl_hold;
    end
  end

  // i2s record path
  // off while the i2s sub-block or the whole controller is held
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      i2s_record_en_o <= 1'b0;
    end
    else if (ce_i)
    begin
      i2s_record_en_o <= ctrl[asrp_pkg::I2S_REC_BIT] & ~i2s_hold;
    end
  end

  // i2s playback path
  // off while the i2s sub-block or the whole controller is held
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      i2s_play_en_o <= 1'b0;
    end
    else if (ce_i)
    begin
      i2s_play_en_o <= ctrl[asrp_pkg::I2S_PLAY_BIT] & ~i2s_hold;
    end
  end

  // dma countdown helper
  // follows the global reset only; the sub-block bits do not touch it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dma_count_en_o <= 1'b0;
    end
    else if (ce_i)
    begin
      dma_count_en_o <= ctrl[asrp_pkg::CNT_EN_BIT] & ~glb_hold;
    end
  end

  // dma zero and sign detection helper
  // follows the global reset only; the sub-block bits do not touch it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dma_zero_det_en_o <= 1'b0;
    end
    else if (ce_i)
    begin
      dma_zero_det_en_o <= ctrl[asrp_pkg::ZERO_EN_BIT] & ~glb_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word, read only; it mirrors the outputs, not the control word,
  // so software can see when a change has reached the sub-blocks
  //   [0]    i2s sub-block reset out
  //   [1]    codec-link sub-block reset out
  //   [2]    global reset out
  //   [3]    record left open
  //   [4]    record right open
  //   [5]    playback stereo
  //   [6]    playback mono
  //   [7]    record code reserved while the converter is not the source
  //   [8]    playback code reserved
  //   [31:9] zero

  assign stat[asrp_pkg::ST_I2S_RST]   = i2s_subblock_rst_o;
  assign stat[asrp_pkg::ST_CL_RST]    = codec_link_subblock_rst_o;
  assign stat[asrp_pkg::ST_GLB_RST]   = audio_ctrl_global_rst_o;
  assign stat[asrp_pkg::ST_REC_LEFT]  = rec_left_en_o;
  assign stat[asrp_pkg::ST_REC_RIGHT] = rec_right_en_o;
  assign stat[asrp_pkg::ST_PLAY_ST]   = play_stereo_o;
  assign stat[asrp_pkg::ST_PLAY_MONO] = play_mono_o;
  assign stat[31:asrp_pkg::ST_PLAY_BAD+1] = '0;

endmodule
`default_nettype wire

// File: tb/asrp_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module asrp_ctrl_properties
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        adc_src_i,
  input wire logic        audio_ctrl_global_rst_o,
  input wire logic        i2s_subblock_rst_o,
  input wire logic        codec_link_subblock_rst_o,
  input wire logic        codec_link_record_en_o,
  input wire logic        codec_link_play_en_o,
  input wire logic        i2s_record_en_o,
  input wire logic        i2s_play_en_o,
  input wire logic        dma_count_en_o,
  input wire logic        dma_zero_det_en_o,
  input wire logic        rec_left_en_o,
  input wire logic        rec_right_en_o,
  input wire logic        play_stereo_o,
  input wire logic        play_mono_o
);
  logic [31:0] sh;
  logic [31:0] ps;
  logic        pa;
  logic        rq;
  logic [31:0] bm;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // writable lanes; reserved bits never stick
  assign bm = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}}
              & asrp_pkg::CTRL_WMASK;
  // shadow of the control word, plus a delayed copy since outputs lag ctrl by an edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sh <= '0;
    else if (ce_i && cyc_i && stb_i && we_i && !ack_o && adr_i == asrp_pkg::CTRL_ADDR)
      sh <= (sh & ~bm) | (dat_i & bm);
  end
  // copies move only on enabled edges, like the outputs; rq covers the one
  // enabled edge after reset at which the reset outputs are still high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ps <= '0;
      pa <= 1'b0;
      rq <= 1'b1;
    end
    else if (ce_i)
    begin
      ps <= sh;
      pa <= adc_src_i;
      rq <= 1'b0;
    end
  end
  sequence wb_req;
    ce_i && cyc_i && stb_i && !ack_o;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  ack_resp_a: assert property (wb_req |=> ack_o)
    else $error("request not acknowledged");
  ack_pulse_a: assert property ((ack_o && ce_i) |=> !ack_o)
    else $error("ack longer than one cycle");
  rd_ctrl_a: assert property (
    wb_req ##0 (!we_i && adr_i == asrp_pkg::CTRL_ADDR) |=> dat_o == ps)
    else $error("control read data wrong");
  glb_rst_a: assert property (audio_ctrl_global_rst_o == (rq | ps[16]))
    else $error("global reset out wrong");
  sub_rst_a: assert property (
    i2s_subblock_rst_o == (rq | ps[16] | ps[0]) &&
    codec_link_subblock_rst_o == (rq | ps[16] | ps[1]))
    else $error("sub-block reset out wrong");
  path_en_a: assert property (
    {codec_link_record_en_o, codec_link_play_en_o} == (ps[8:7] & ~{2{ps[16] | ps[1]}}) &&
    {i2s_record_en_o, i2s_play_en_o} == (ps[6:5] & ~{2{ps[16] | ps[0]}}))
    else $error("path enable wrong");
  dma_en_a: assert property (
    {dma_count_en_o, dma_zero_det_en_o} == (ps[4:3] & ~{2{ps[16]}}))
    else $error("dma enable wrong");
  rec_chan_a: assert property (
    rec_left_en_o == (pa | ps[14]) && rec_right_en_o == (!pa & ps[15]))
    else $error("record channel wrong");
  play_chan_a: assert property (
    play_stereo_o == (ps[13:12] == 2'h3) && play_mono_o == (ps[13:12] == 2'h2))
    else $error("playback layout wrong");
  ce_hold_a: assert property ((!ce_i && !ack_o) |=> !ack_o)
    else $error("ack raised while clock enable low");
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, adc_src_i, probe;
  logic [31:0] adr_i, dat_i, dat_o, ctrl, d, v, e;
  logic [3:0]  sel_i, s;
  logic        ack_o, audio_ctrl_global_rst_o, i2s_subblock_rst_o, codec_link_subblock_rst_o;
  logic        codec_link_record_en_o, codec_link_play_en_o, i2s_record_en_o, i2s_play_en_o;
  logic        dma_count_en_o, dma_zero_det_en_o, rec_left_en_o, rec_right_en_o;
  logic        play_stereo_o, play_mono_o;
  logic [12:0] outs;
  logic [31:0] q[$];
  int          bad_count, checks_done, seed;
  asrp_ctrl uut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .adc_src_i, .audio_ctrl_global_rst_o, .i2s_subblock_rst_o, .codec_link_subblock_rst_o,
    .codec_link_record_en_o, .codec_link_play_en_o, .i2s_record_en_o, .i2s_play_en_o,
    .dma_count_en_o, .dma_zero_det_en_o, .rec_left_en_o, .rec_right_en_o, .play_stereo_o,
    .play_mono_o);
  assign outs = {audio_ctrl_global_rst_o, i2s_subblock_rst_o, codec_link_subblock_rst_o,
    codec_link_record_en_o, codec_link_play_en_o, i2s_record_en_o, i2s_play_en_o,
    dma_count_en_o, dma_zero_det_en_o, rec_left_en_o, rec_right_en_o, play_stereo_o, play_mono_o};
  ////////////////////////////////////////////////////////////////////////////
  // expected port picture: enables gated by their own reset bits
  function automatic logic [31:0] exp_outs(input logic [31:0] c, input logic a);
    logic g, ir, cr;
    g = c[16];
    ir = g | c[0];
    cr = g | c[1];
    return {19'h0, g, ir, cr, c[8] & ~cr, c[7] & ~cr, c[6] & ~ir, c[5] & ~ir, c[4] & ~g,
      c[3] & ~g, a | c[14], ~a & c[15], c[13:12] == 2'h3, c[13:12] == 2'h2};
  endfunction
  // status word as the outputs should show it
  function automatic logic [31:0] exp_stat(input logic [31:0] c, input logic a);
    logic [31:0] o;
    o = exp_outs(c, a);
    return {23'h0, ~c[13], ~a & (c[15:14] == 2'h0), o[0], o[1], o[2], o[3], o[12], o[10], o[11]};
  endfunction
  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] dd, input logic [3:0] ss);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, dd, ss};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1)
    begin
      bad_count++;
      $display("[ERR] ack_o expected 1 seen %b", ack_o);
      finish_test();
    end
    else
      {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] dd, input logic [3:0] ss);
    logic [31:0] m;
    m = {{8{ss[3]}}, {8{ss[2]}}, {8{ss[1]}}, {8{ss[0]}}} & 32'h0001_f1fb;
    if (a == 32'hb000_9004)
      ctrl = (ctrl & ~m) | (dd & m);
    wb(1'b1, a, dd, ss);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    q.push_back(x);
    wb(1'b0, a, 32'h0000_0000, 4'hf);
  endtask
  task automatic chk_outs(input logic [31:0] x);
    q.push_back(x);
    @(posedge clk_i);
    probe <= 1'b1;
    @(posedge clk_i);
    probe <= 1'b0;
  endtask
  // scoreboard: read data on ack, port picture on probe
  always @(negedge clk_i)
  begin
    if (probe === 1'b1 || (ack_o === 1'b1 && we_i === 1'b0))
    begin
      e = q.pop_front();
      v = probe ? {19'h0, outs} : dat_o;
      checks_done++;
      if (v !== e)
      begin
        bad_count++;
        $display("[ERR] %s expected %h seen %h", probe ? "outputs" : "dat_o", e, v);
      end
    end
  end
  // 50 ns clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial
  begin
    {rst_i, ce_i, cyc_i, stb_i, we_i, adc_src_i, probe} = 7'b1100000;
    {adr_i, dat_i, sel_i, ctrl, bad_count, checks_done, seed} = '0;
    seed = 5;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_outs(32'h0000_0000);
    rd(32'hb000_9004, 32'h0000_0000);
    wr(32'hb000_9004, 32'hffff_ffff, 4'hf);
    rd(32'hb000_9004, 32'h0001_f1fb);
    // every channel code with all lanes and no converter source, then random lanes with the converter source
    for (int i = 0; i < 32; i++)
    begin
      d = $random(seed);
      d[15:12] = {i[1:0], i[3:2]};
      s = (i < 16) ? 4'hf : 4'($random(seed));
      adc_src_i <= i[4];
      wr(32'hb000_9004, d, s);
      rd(32'hb000_9004, ctrl);
      rd(32'hb000_904c, exp_stat(ctrl, i[4]));
      chk_outs(exp_outs(ctrl, i[4]));
    end
    // unmapped and status places leave the control word alone
    wr(32'hb000_9008, 32'hffff_ffff, 4'hf);
    wr(32'hb000_904c, 32'hffff_ffff, 4'hf);
    rd(32'hb000_9008, 32'h0000_0000);
    rd(32'hb000_9004, ctrl);
    // a write held up by the clock enable lands once it returns
    ce_i <= 1'b0;
    fork
      wr(32'hb000_9004, 32'h0000_6150, 4'hf);
      begin
        repeat (4) @(posedge clk_i);
        ce_i <= 1'b1;
      end
    join
    rd(32'hb000_9004, ctrl);
    chk_outs(exp_outs(ctrl, adc_src_i));
    // reset again in mid-run
    rst_i <= 1'b1;
    chk_outs(32'h0000_1c00);
    rst_i <= 1'b0;
    ctrl = '0;
    rd(32'hb000_9004, 32'h0000_0000);
    chk_outs(exp_outs(32'h0000_0000, adc_src_i));
    finish_test();
  end
endmodule
bind asrp_ctrl asrp_ctrl_properties u_props (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .adc_src_i, .audio_ctrl_global_rst_o,
  .i2s_subblock_rst_o, .codec_link_subblock_rst_o, .codec_link_record_en_o,
  .codec_link_play_en_o, .i2s_record_en_o, .i2s_play_en_o, .dma_count_en_o,
  .dma_zero_det_en_o, .rec_left_en_o, .rec_right_en_o, .play_stereo_o, .play_mono_o);
`default_nettype wire
